//--- design/fsled_regs.svh
// register map, field positions, reset values and timing figures of the led controller
`ifndef FSLED_REGS_SVH
`define FSLED_REGS_SVH
// ====================================
// clock and timing
`define FSLED_CLK_HZ 100000000.0
`define FSLED_PREOP_BLINK_HZ 0.4
`define FSLED_SAFEOP_BLINK_HZ 1.2
`define FSLED_BOOT_FLICKER_HZ 10.0
`define FSLED_POWERUP_S 15.0
`define FSLED_LINK_STRETCH_MS 50.0
`define FSLED_LINE_RATE_MBPS 100
// ====================================
// register offsets
`define FSLED_ADDR_W 8
`define FSLED_CTRL_ADDR 8'h00
`define FSLED_STATUS_ADDR 8'h04
`define FSLED_ISTAT_ADDR 8'h08
`define FSLED_IMASK_ADDR 8'h0C
// ====================================
// fields
`define FSLED_ESM_W 4
`define FSLED_CTRL_CPL_LSB 0
`define FSLED_CTRL_MOD_LSB 4
`define FSLED_CTRL_HOST_BIT 8
`define FSLED_CTRL_FB_BIT 9
`define FSLED_STAT_RED_LSB 8
`define FSLED_IRQ_W 4
`define FSLED_IRQ_STATE 0
`define FSLED_IRQ_FAULT 1
`define FSLED_IRQ_PWRUP 2
`define FSLED_IRQ_LINK 3
`define FSLED_IMASK_RESET 4'h0
`define FSLED_PAIR_THRESHOLD 4
`endif

//--- design/fsled_pkg.sv
// types shared by the led controller modules
package fsled_pkg;
  typedef enum logic [3:0] {
    FSLED_ESM_INIT = 4'h1,
    FSLED_ESM_PREOP = 4'h2,
    FSLED_ESM_BOOT = 4'h3,
    FSLED_ESM_SAFEOP = 4'h4,
    FSLED_ESM_OP = 4'h8
  } fsled_esm_type;
endpackage

//--- design/fsled_ifs.sv
// interfaces between the controller top and its pattern and health modules
`timescale 1ns/10ps
interface fsled_led_if;
  logic [3:0] esm_state;
  logic led;
  modport src (output esm_state, input led);
  modport gen (input esm_state, output led);
endinterface

interface fsled_health_if #(parameter int CHANNELS = 8);
  localparam int LEDS = (CHANNELS > 4) ? (CHANNELS + 1) / 2 : CHANNELS;
  logic [CHANNELS-1:0] cfg_valid;
  logic [CHANNELS-1:0] fault;
  logic [LEDS-1:0] green;
  logic [LEDS-1:0] red;
  modport mon (output cfg_valid, output fault, input green, input red);
  modport hlt (input cfg_valid, input fault, output green, output red);
endinterface

//--- design/fsled_blink.sv
// blink pattern generator for one state indicator
`timescale 1ns/10ps
`include "fsled_regs.svh"
module fsled_blink import fsled_pkg::*; #(
  parameter int unsigned PREOP_HALF = $rtoi(`FSLED_CLK_HZ / (2.0 * `FSLED_PREOP_BLINK_HZ)),
  parameter int unsigned SAFEOP_HALF = $rtoi(`FSLED_CLK_HZ / (2.0 * `FSLED_SAFEOP_BLINK_HZ)),
  parameter int unsigned BOOT_HALF = $rtoi(`FSLED_CLK_HZ / (2.0 * `FSLED_BOOT_FLICKER_HZ))
) (
  input wire logic clk,
  input wire logic rst_n,
  fsled_led_if.gen pat
);
  typedef struct packed {
    logic [3:0] prev;
    logic [31:0] cnt;
    logic led;
  } fsled_blink_state_type;
  fsled_blink_state_type cur_reg, cur_next;
  logic [31:0] half;

  // ====================================
  // pattern
  always_comb begin
    cur_next = cur_reg;
    case (fsled_esm_type'(pat.esm_state))
      FSLED_ESM_PREOP: half = PREOP_HALF;
      FSLED_ESM_SAFEOP: half = SAFEOP_HALF;
      FSLED_ESM_BOOT: half = BOOT_HALF;
      default: half = 32'h0;
    endcase
    if (pat.esm_state != cur_reg.prev) begin
      // restart blinking states and op in the lit phase so they show at once; init and unknown codes restart dark
      cur_next.prev = pat.esm_state;
      cur_next.cnt = 32'h0;
      cur_next.led = (half != 32'h0) || (pat.esm_state == FSLED_ESM_OP);
    end else if (half == 32'h0) begin
      cur_next.cnt = 32'h0;
      cur_next.led = (pat.esm_state == FSLED_ESM_OP);
    end else if (cur_reg.cnt >= half - 32'h1) begin
      cur_next.cnt = 32'h0;
      cur_next.led = ~cur_reg.led;
    end else begin
      cur_next.cnt = cur_reg.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_reg <= '{prev: FSLED_ESM_INIT, cnt: 32'h0, led: 1'b0};
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign pat.led = cur_reg.led;

  restart_clean_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pat.esm_state != cur_reg.prev) |=> (cur_reg.cnt == 32'h0))
    else $error("pattern counter not restarted on state change");
endmodule

//--- design/fsled_health.sv
// green/red health indicators per channel, or per channel pair above four channels
`timescale 1ns/10ps
`include "fsled_regs.svh"
module fsled_health #(
  parameter int CHANNELS = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  fsled_health_if.hlt hif
);
  localparam int LEDS = (CHANNELS > `FSLED_PAIR_THRESHOLD) ? (CHANNELS + 1) / 2 : CHANNELS;
  typedef struct packed {
    logic [LEDS-1:0] green;
    logic [LEDS-1:0] red;
  } fsled_health_state_type;
  fsled_health_state_type cur_reg, cur_next;
  logic [LEDS-1:0] ok_w;
  logic [LEDS-1:0] bad_w;

  // ====================================
  // channel grouping; only analog channel flags come in, digital i/o never reaches here
  for (genvar i = 0; i < LEDS; i++) begin : g_led
    if (CHANNELS > `FSLED_PAIR_THRESHOLD && (2 * i + 1) < CHANNELS) begin : g_pair
      assign bad_w[i] = hif.fault[2*i] | hif.fault[2*i+1];
      assign ok_w[i] = hif.cfg_valid[2*i] & hif.cfg_valid[2*i+1];
    end else if (CHANNELS > `FSLED_PAIR_THRESHOLD) begin : g_odd
      assign bad_w[i] = hif.fault[2*i];
      assign ok_w[i] = hif.cfg_valid[2*i];
    end else begin : g_single
      assign bad_w[i] = hif.fault[i];
      assign ok_w[i] = hif.cfg_valid[i];
    end
  end

  always_comb begin
    cur_next.red = bad_w;
    cur_next.green = ok_w & ~bad_w;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign hif.green = cur_reg.green;
  assign hif.red = cur_reg.red;

  colour_exclusive_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_reg.green & cur_reg.red) == '0)
    else $error("channel led shows green and red together");
endmodule

//--- design/fsled_ctrl.sv
// status led controller: coupler run/link leds and module run/state/channel leds
`timescale 1ns/10ps
`include "fsled_regs.svh"
// Functional notes
// - run led dark in init, about 0.4 Hz in pre-op, 1.2 Hz in safe-op
// - run led flickers fast in bootstrap and stays lit in operational
// - separate link leds for upstream port, module link and downstream port
// - fieldbus ports run at 100 Mbit/s
// - module run led lit steadily after about 15 s power-up when connected
// - module run led blinks while configuration software holds a connection
// - module run led steady while communicating over the fieldbus
// - module state led uses the coupler run led patterns for its own state
// - channel led green when configured and fault free, red on fault
// - above four inputs one led covers two channels, red if either errs
// - digital inputs and outputs never affect the channel leds
module fsled_ctrl import fsled_pkg::*; #(
  parameter int CHANNELS = 8,
  parameter int unsigned PREOP_HALF = $rtoi(`FSLED_CLK_HZ / (2.0 * `FSLED_PREOP_BLINK_HZ)),
  parameter int unsigned SAFEOP_HALF = $rtoi(`FSLED_CLK_HZ / (2.0 * `FSLED_SAFEOP_BLINK_HZ)),
  parameter int unsigned BOOT_HALF = $rtoi(`FSLED_CLK_HZ / (2.0 * `FSLED_BOOT_FLICKER_HZ)),
  parameter int unsigned POWERUP_CYC = $rtoi(`FSLED_CLK_HZ * `FSLED_POWERUP_S),
  parameter int unsigned LINK_STRETCH = $rtoi(`FSLED_CLK_HZ * `FSLED_LINK_STRETCH_MS / 1000.0),
  parameter int LEDS = (CHANNELS > `FSLED_PAIR_THRESHOLD) ? (CHANNELS + 1) / 2 : CHANNELS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`FSLED_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic upstream_port_up,
  input wire logic upstream_port_100m,
  input wire logic upstream_port_act,
  input wire logic module_link_up,
  input wire logic module_link_act,
  input wire logic downstream_port_up,
  input wire logic downstream_port_100m,
  input wire logic downstream_port_act,
  input wire logic module_connected,
  input wire logic [CHANNELS-1:0] chan_cfg_valid,
  input wire logic [CHANNELS-1:0] chan_fault,
  output logic coupler_run_led,
  output logic upstream_link_led,
  output logic module_link_led,
  output logic downstream_link_led,
  output logic module_run_led,
  output logic module_state_led,
  output logic [LEDS-1:0] chan_green_led,
  output logic [LEDS-1:0] chan_red_led
);
  localparam int STR_W = $clog2(LINK_STRETCH + 1);
  localparam int IW = `FSLED_IRQ_W;
  localparam int EW = `FSLED_ESM_W;
  localparam logic [STR_W-1:0] STR_FULL = STR_W'(LINK_STRETCH);
  localparam logic [STR_W-1:0] STR_HALF = STR_W'(LINK_STRETCH / 2);
  localparam logic [30:0] PU_LAST = 31'(POWERUP_CYC - 1);

  typedef struct packed {
    logic [EW-1:0] coupler_state;
    logic [EW-1:0] module_state;
    logic host_conn;
    logic fb_comm;
    logic [IW-1:0] istat;
    logic [IW-1:0] imask;
    logic [31:0] rdata;
    logic irq;
    logic [30:0] pu_cnt;
    logic pu_done;
    logic [2:0][STR_W-1:0] stretch;
    logic [2:0] link_ok_prev;
    logic [2:0] link_led;
    logic run_led;
    logic [LEDS-1:0] red_prev;
    logic in_step;
  } fsled_top_state_type;

  fsled_top_state_type cur_reg, cur_next;
  logic [2:0] link_ok;
  logic [2:0] link_act;
  logic [IW-1:0] ev_set;
  logic [IW-1:0] ev_clr;
  logic [31:0] status_w;
  logic wr_ctrl;
  logic [EW-1:0] new_cpl;
  logic [EW-1:0] new_mod;

  // ====================================
  // pattern and health submodules
  fsled_led_if cpl_if();
  fsled_led_if mod_if();
  fsled_led_if host_if();
  fsled_health_if #(.CHANNELS(CHANNELS)) hlt_if();

  assign cpl_if.esm_state = cur_reg.coupler_state;
  assign mod_if.esm_state = cur_reg.module_state;
  // the host blink only needs a running pre-op pattern while the link is held
  assign host_if.esm_state = cur_reg.host_conn ? FSLED_ESM_PREOP : FSLED_ESM_OP;
  assign hlt_if.cfg_valid = chan_cfg_valid;
  assign hlt_if.fault = chan_fault;

  fsled_blink #(.PREOP_HALF(PREOP_HALF), .SAFEOP_HALF(SAFEOP_HALF), .BOOT_HALF(BOOT_HALF))
    u_cpl_blink (.clk(clk), .rst_n(rst_n), .pat(cpl_if.gen));
  fsled_blink #(.PREOP_HALF(PREOP_HALF), .SAFEOP_HALF(SAFEOP_HALF), .BOOT_HALF(BOOT_HALF))
    u_mod_blink (.clk(clk), .rst_n(rst_n), .pat(mod_if.gen));
  fsled_blink #(.PREOP_HALF(PREOP_HALF), .SAFEOP_HALF(SAFEOP_HALF), .BOOT_HALF(BOOT_HALF))
    u_host_blink (.clk(clk), .rst_n(rst_n), .pat(host_if.gen));
  fsled_health #(.CHANNELS(CHANNELS)) u_health (.clk(clk), .rst_n(rst_n), .hif(hlt_if.hlt));

  // ====================================
  // link qualification
  // fieldbus ports count as up only at the nominal line rate
  assign link_ok[0] = upstream_port_up & upstream_port_100m;
  assign link_ok[1] = module_link_up;
  assign link_ok[2] = downstream_port_up & downstream_port_100m;
  assign link_act = {downstream_port_act, module_link_act, upstream_port_act};
  assign wr_ctrl = reg_wr && (reg_addr == `FSLED_CTRL_ADDR);
  assign new_cpl = reg_wdata[`FSLED_CTRL_CPL_LSB +: EW];
  assign new_mod = reg_wdata[`FSLED_CTRL_MOD_LSB +: EW];

  always_comb begin
    status_w = 32'h0;
    status_w[0] = coupler_run_led;
    status_w[3:1] = cur_reg.link_led;
    status_w[4] = cur_reg.run_led;
    status_w[5] = module_state_led;
    status_w[6] = cur_reg.pu_done;
    status_w = status_w | (32'(hlt_if.red) << `FSLED_STAT_RED_LSB);
  end

  // ====================================
  // next state
  always_comb begin
    cur_next = cur_reg;
    ev_set = '0;
    ev_clr = '0;
    // control register
    if (wr_ctrl) begin
      cur_next.coupler_state = reg_wdata[`FSLED_CTRL_CPL_LSB +: EW];
      cur_next.module_state = reg_wdata[`FSLED_CTRL_MOD_LSB +: EW];
      cur_next.host_conn = reg_wdata[`FSLED_CTRL_HOST_BIT];
      cur_next.fb_comm = reg_wdata[`FSLED_CTRL_FB_BIT];
      ev_set[`FSLED_IRQ_STATE] = reg_wdata[`FSLED_CTRL_CPL_LSB +: EW] != cur_reg.coupler_state;
      // the two state leds share a phase only when both patterns restart on one write
      cur_next.in_step = (new_cpl == new_mod) &&
        ((new_cpl != cur_reg.coupler_state) == (new_mod != cur_reg.module_state)) &&
        (cur_reg.in_step || (new_cpl != cur_reg.coupler_state));
    end
    if (reg_wr && reg_addr == `FSLED_IMASK_ADDR) begin
      cur_next.imask = reg_wdata[IW-1:0];
    end
    if (reg_wr && reg_addr == `FSLED_ISTAT_ADDR) begin
      ev_clr = reg_wdata[IW-1:0];
    end
    // power-up timer
    if (!cur_reg.pu_done) begin
      if (cur_reg.pu_cnt == PU_LAST) begin
        cur_next.pu_done = 1'b1;
        ev_set[`FSLED_IRQ_PWRUP] = 1'b1;
      end else begin
        cur_next.pu_cnt = cur_reg.pu_cnt + 31'h1;
      end
    end
    // module run led: steady on the bus, blinking for the host, else steady
    cur_next.run_led = cur_reg.pu_done && module_connected &&
      (cur_reg.fb_comm || !cur_reg.host_conn || host_if.led);
    // link leds: lit while up, a dark half-stretch per burst of traffic
    for (int i = 0; i < 3; i++) begin
      if (!link_ok[i]) begin
        cur_next.stretch[i] = '0;
      end else if (cur_reg.stretch[i] == '0) begin
        cur_next.stretch[i] = link_act[i] ? STR_FULL : '0;
      end else begin
        cur_next.stretch[i] = cur_reg.stretch[i] - STR_W'(1);
      end
      cur_next.link_led[i] = link_ok[i] && (cur_next.stretch[i] <= STR_HALF);
    end
    cur_next.link_ok_prev = link_ok;
    ev_set[`FSLED_IRQ_LINK] = |(cur_reg.link_ok_prev & ~link_ok);
    // new channel fault
    cur_next.red_prev = hlt_if.red;
    ev_set[`FSLED_IRQ_FAULT] = |(hlt_if.red & ~cur_reg.red_prev);
    // set wins over a write-one clear in the same cycle
    cur_next.istat = (cur_reg.istat & ~ev_clr) | ev_set;
    cur_next.irq = |(cur_next.istat & cur_next.imask);
    // read data stands one cycle after the strobe, zero otherwise
    cur_next.rdata = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        `FSLED_CTRL_ADDR: begin
          cur_next.rdata[`FSLED_CTRL_CPL_LSB +: EW] = cur_reg.coupler_state;
          cur_next.rdata[`FSLED_CTRL_MOD_LSB +: EW] = cur_reg.module_state;
          cur_next.rdata[`FSLED_CTRL_HOST_BIT] = cur_reg.host_conn;
          cur_next.rdata[`FSLED_CTRL_FB_BIT] = cur_reg.fb_comm;
        end
        `FSLED_STATUS_ADDR: begin
          cur_next.rdata = status_w;
        end
        `FSLED_ISTAT_ADDR: begin
          cur_next.rdata[IW-1:0] = cur_reg.istat;
        end
        `FSLED_IMASK_ADDR: begin
          cur_next.rdata[IW-1:0] = cur_reg.imask;
        end
        default: begin
          cur_next.rdata = 32'h0;
        end
      endcase
    end
  end

  // ====================================
  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_reg <= '0;
      cur_reg.coupler_state <= FSLED_ESM_INIT;
      cur_reg.module_state <= FSLED_ESM_INIT;
      cur_reg.imask <= `FSLED_IMASK_RESET;
      cur_reg.in_step <= 1'b1;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // ====================================
  // outputs
  assign reg_rdata = cur_reg.rdata;
  assign irq = cur_reg.irq;
  assign coupler_run_led = cpl_if.led;
  assign module_state_led = mod_if.led;
  assign upstream_link_led = cur_reg.link_led[0];
  assign module_link_led = cur_reg.link_led[1];
  assign downstream_link_led = cur_reg.link_led[2];
  assign module_run_led = cur_reg.run_led;
  assign chan_green_led = hlt_if.green;
  assign chan_red_led = hlt_if.red;

  // ====================================
  // checks
  init_dark_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_reg.coupler_state == FSLED_ESM_INIT) [*3] |-> !coupler_run_led)
    else $error("run led lit in init state");

  op_steady_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_reg.coupler_state == FSLED_ESM_OP) [*3] |-> coupler_run_led)
    else $error("run led dark in operational state");

  mirror_state_a: assert property (@(posedge clk) disable iff (!rst_n)
    cur_reg.in_step [*3] |-> (module_state_led == coupler_run_led))
    else $error("state led pattern differs from run led");

  link_down_a: assert property (@(posedge clk) disable iff (!rst_n)
    !module_link_up |=> !module_link_led)
    else $error("module link led lit with link down");

  up_rate_a: assert property (@(posedge clk) disable iff (!rst_n)
    !upstream_port_100m |=> !upstream_link_led)
    else $error("upstream led lit below line rate");

  down_rate_a: assert property (@(posedge clk) disable iff (!rst_n)
    !downstream_port_100m |=> !downstream_link_led)
    else $error("downstream led lit below line rate");

  powerup_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    module_run_led |-> cur_reg.pu_done)
    else $error("run led lit before power-up ended");

  bus_steady_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_reg.pu_done && module_connected && cur_reg.fb_comm) |=> module_run_led)
    else $error("run led not steady on fieldbus traffic");

  pwrup_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(cur_reg.pu_done) |-> cur_reg.istat[`FSLED_IRQ_PWRUP])
    else $error("power-up flag lost");

  irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    irq == |(cur_reg.istat & cur_reg.imask))
    else $error("interrupt line disagrees with flags");

  ctrl_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == `FSLED_CTRL_ADDR) |=>
      (reg_rdata[`FSLED_CTRL_CPL_LSB +: EW] == $past(cur_reg.coupler_state)))
    else $error("control read back wrong");

  state_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_ctrl && new_cpl != cur_reg.coupler_state) |=> cur_reg.istat[`FSLED_IRQ_STATE])
    else $error("state change flag not set");

  link_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    (|(cur_reg.link_ok_prev & ~link_ok)) |=> cur_reg.istat[`FSLED_IRQ_LINK])
    else $error("link loss flag not set");

  read_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !reg_rd |=> (reg_rdata == 32'h0))
    else $error("read data stands outside its cycle");

  host_blink_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_reg.pu_done && module_connected && cur_reg.host_conn && !cur_reg.fb_comm) |=>
      (module_run_led == $past(host_if.led)))
    else $error("run led does not follow the host blink");

  dark_flash_a: assert property (@(posedge clk) disable iff (!rst_n)
    (link_ok[0] && link_act[0] && cur_reg.stretch[0] == '0) |=> !upstream_link_led)
    else $error("no dark flash on upstream traffic");
endmodule

//--- tb/fsled_link_partner.sv
// far-side model: the fieldbus ports and the module link as seen by the led controller
`timescale 1ns/10ps
module fsled_link_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] up_cmd,
  input wire logic fast_cmd,
  input wire logic [2:0] act_cmd,
  output logic [2:0] link_up,
  output logic [2:0] link_100m,
  output logic [2:0] link_act
);
  // ====================================
  // link state follows the bench, one register of lag like a real phy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_up <= 3'h0;
      link_100m <= 3'h0;
      link_act <= 3'h0;
    end else begin
      link_up <= up_cmd;
      // a link that is down never reports a rate
      link_100m <= fast_cmd ? up_cmd : 3'h0;
      // no frames on a dead link
      link_act <= act_cmd & up_cmd;
    end
  end
endmodule

//--- tb/fieldbus_status_led_ctrl_tb.sv
// self-checking bench of the status led controller
`timescale 1ns/10ps
`include "fsled_regs.svh"
module fieldbus_status_led_ctrl_tb;
  import fsled_pkg::*;
  // ====================================
  // short counts keep the run brief
  localparam int PRE = 20;
  localparam int SAFE = 7;
  localparam int BOOT = 3;
  localparam int PU = 50;
  localparam int STR = 8;
  logic clk, rst_n, reg_wr, reg_rd, irq, module_connected, rd_q, fast_cmd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, exp_v;
  logic [2:0] up_cmd, act_cmd, lup, l100, lact;
  logic [7:0] cfg, flt;
  logic [3:0] gl, rl, eg, er;
  logic [5:0] leds;
  logic [31:0] exp_q[$];
  int err_count, n_checks, seed, cyc, n;
  int codes[5] = '{1, 2, 4, 3, 5};
  int halves[5] = '{0, PRE, SAFE, BOOT, 0};

  fsled_ctrl #(.CHANNELS(8), .PREOP_HALF(PRE), .SAFEOP_HALF(SAFE), .BOOT_HALF(BOOT),
    .POWERUP_CYC(PU), .LINK_STRETCH(STR)) i_dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .upstream_port_up(lup[0]), .upstream_port_100m(l100[0]), .upstream_port_act(lact[0]),
    .module_link_up(lup[1]), .module_link_act(lact[1]),
    .downstream_port_up(lup[2]), .downstream_port_100m(l100[2]),
    .downstream_port_act(lact[2]), .module_connected(module_connected),
    .chan_cfg_valid(cfg), .chan_fault(flt), .coupler_run_led(leds[0]),
    .upstream_link_led(leds[3]), .module_link_led(leds[4]), .downstream_link_led(leds[5]),
    .module_run_led(leds[2]), .module_state_led(leds[1]),
    .chan_green_led(gl), .chan_red_led(rl));

  fsled_link_partner i_partner (.clk(clk), .rst_n(rst_n), .up_cmd(up_cmd),
    .fast_cmd(fast_cmd), .act_cmd(act_cmd), .link_up(lup), .link_100m(l100),
    .link_act(lact));

  always #5 clk = ~clk;
  always @(posedge clk) cyc <= rst_n ? cyc + 1 : 0;

  task automatic give_verdict();
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  // ====================================
  // register bus: read data are compared one cycle later by the monitor
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    // one idle edge so the next strobe is never set in the step that drops this one
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask

  always @(posedge clk) rd_q <= reg_rd;
  always @(negedge clk) begin
    if (rd_q === 1'b1) begin
      exp_v = exp_q.pop_front();
      chk(reg_rdata, exp_v);
    end
  end

  // ====================================
  // led timing, sampled at the edge so values are settled
  task automatic wait_for(input int s, input logic v, input int lim);
    n = 0;
    while (leds[s] !== v) begin
      if (n == lim) begin
        err_count++;
        give_verdict();
      end
      @(posedge clk);
      n++;
    end
  endtask

  task automatic run_len(input int s, input logic v, input int lim);
    n = 0;
    while (leds[s] === v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic blink(input int s, input int half);
    wait_for(s, 1'b0, 2 * half + 8);
    wait_for(s, 1'b1, half + 4);
    run_len(s, 1'b1, half + 4);
    chk(n, half);
    run_len(s, 1'b0, half + 4);
    chk(n, half);
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    module_connected = 1'b1;
    fast_cmd = 1'b1;
    up_cmd = 3'h0;
    act_cmd = 3'h0;
    cfg = 8'h00;
    flt = 8'h00;
    seed = 81832;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h11);
    rd(8'h0C, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h04, 32'h0);
    wr(8'h04, 32'hFFFF);
    rd(8'h04, 32'h0);
    // run led holds off until the power-up time has passed
    wait_for(2, 1'b1, PU + 20);
    chk(cyc >= PU, 1'b1);
    rd(8'h08, 32'h4);
    wr(8'h08, 32'h4);
    rd(8'h08, 32'h0);
    wr(8'h0C, 32'hF);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    wr(8'h00, 32'h18);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    rd(8'h08, 32'h1);
    wr(8'h0C, 32'h0);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    wr(8'h08, 32'h1);
    wr(8'h0C, 32'hF);
    run_len(0, 1'b1, 40);
    chk(n, 40);
    chk(irq, 1'b0);
    // init, pre-op, safe-op and bootstrap codes on both state leds, plus one unused code
    for (int i = 0; i < 5; i++) begin
      wr(8'h00, 32'(codes[i] | (codes[i] << 4)));
      repeat (2) @(posedge clk);
      if (halves[i] == 0) begin
        run_len(0, 1'b0, 40);
        chk(n, 40);
        run_len(1, 1'b0, 40);
        chk(n, 40);
      end else begin
        chk(leds[0], 1'b1);
        blink(0, halves[i]);
        blink(1, halves[i]);
      end
    end
    wr(8'h00, 32'h111);
    blink(2, PRE);
    wr(8'h00, 32'h311);
    repeat (2) @(posedge clk);
    run_len(2, 1'b1, 40);
    chk(n, 40);
    module_connected <= 1'b0;
    repeat (3) @(posedge clk);
    chk(leds[2], 1'b0);
    module_connected <= 1'b1;
    // random channel health, pairs of channels per led
    for (int k = 0; k < 20; k++) begin
      cfg <= 8'($random(seed));
      flt <= 8'($random(seed) & $random(seed));
      repeat (4) @(posedge clk);
      for (int i = 0; i < 4; i++) begin
        er[i] = flt[2 * i] | flt[2 * i + 1];
        eg[i] = cfg[2 * i] & cfg[2 * i + 1] & ~er[i];
      end
      chk({gl, rl}, {eg, er});
    end
    flt <= 8'h00;
    cfg <= 8'hFF;
    repeat (3) @(posedge clk);
    chk({gl, rl}, 8'hF0);
    wr(8'h08, 32'hF);
    flt <= 8'h02;
    repeat (3) @(posedge clk);
    chk(rl, 4'h1);
    rd(8'h08, 32'h2);
    wr(8'h08, 32'hF);
    // each link lit while up, dark flash on activity
    for (int s = 0; s < 3; s++) begin
      up_cmd[s] <= 1'b1;
      wait_for(3 + s, 1'b1, 10);
      act_cmd[s] <= 1'b1;
      @(posedge clk);
      act_cmd[s] <= 1'b0;
      wait_for(3 + s, 1'b0, 10);
      run_len(3 + s, 1'b0, 20);
      chk(n, STR / 2);
    end
    fast_cmd <= 1'b0;
    repeat (3) @(posedge clk);
    chk(leds[5:3], 3'h2);
    wr(8'h08, 32'hF);
    fast_cmd <= 1'b1;
    up_cmd <= 3'h0;
    repeat (4) @(posedge clk);
    chk(leds[5:3], 3'h0);
    rd(8'h08, 32'h8);
    // second reset in mid-run: irq and every led back to their reset values
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({irq, leds, gl, rl}, 15'h0000);
    rst_n <= 1'b1;
    rd(8'h00, 32'h11);
    repeat (3) @(posedge clk);
    give_verdict();
  end
endmodule
